// [shared/fsp_defines.vh]
// Constants of the flash self-program protection block.
// Assumes inclusion by bare name from verilog/fsp_top.v.
`ifndef FSP_DEFINES_VH
`define FSP_DEFINES_VH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define FSP_OFS_CTRL        8'h00
`define FSP_OFS_LOCK        8'h04
`define FSP_OFS_CONF        8'h08

// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define FSP_CTRL_BUSY       0
`define FSP_CTRL_CLR        1
`define FSP_CTRL_HALT       2

// ----------------------------------------------------------------------
// Lock register fields and reset value
// ----------------------------------------------------------------------
`define FSP_LOCK_APP_LO     0
`define FSP_LOCK_APP_HI     1
`define FSP_LOCK_BOOT_LO    2
`define FSP_LOCK_BOOT_HI    3
`define FSP_LOCK_RST        4'hF

// ----------------------------------------------------------------------
// Config register fields
// ----------------------------------------------------------------------
`define FSP_CONF_FUSE_LSB   0
`define FSP_CONF_BOOT_LSB   16

// ----------------------------------------------------------------------
// Store operation kinds
// ----------------------------------------------------------------------
`define FSP_OP_ERASE        2'h0
`define FSP_OP_WRITE        2'h1
`define FSP_OP_LOCK         2'h2

// ----------------------------------------------------------------------
// AXI responses
// ----------------------------------------------------------------------
`define FSP_RESP_OKAY       2'h0
`define FSP_RESP_SLVERR     2'h2

`endif

// [verilog/fsp_top.v]
// Flash self-program protection: gates program-memory loads and stores
// by code location and lock fields, stalls the CPU for no-read-while-write
// programming and reports region busy over an AXI4-Lite slave.
// Assumes the CPU and flash array run on mclk_i; fuse pins are asynchronous.
`timescale 1ns/100ps
`include "fsp_defines.vh"

module fsp_top #(
    parameter AW         = 13,
    parameter NO_READ_WHILE_WRITE_REGION_START = 13'h1C00,
    parameter BOOT_SZ0   = 13'h0800,
    parameter BOOT_SZ1   = 13'h0400,
    parameter BOOT_SZ2   = 13'h0200,
    parameter BOOT_SZ3   = 13'h0100
) (
    // Clock, reset, enable
    input  wire          mclk_i,
    input  wire          srst_i,
    input  wire          ce_i,
    // Fuse and external programming
    input  wire [1:0]    boot_size_fuses_i,
    input  wire          chip_erase_i,
    input  wire          ext_lock_we_i,
    input  wire [3:0]    ext_lock_d_i,
    // CPU side
    input  wire [AW-1:0] cpu_pc_i,
    input  wire          ivec_boot_i,
    input  wire          spm_req_i,
    input  wire [1:0]    spm_kind_i,
    input  wire [AW-1:0] spm_addr_i,
    input  wire [3:0]    spm_data_i,
    input  wire          lpm_req_i,
    input  wire [AW-1:0] lpm_addr_i,
    output reg           lpm_ok_o,
    output reg           lpm_deny_o,
    output reg           spm_deny_o,
    output reg           cpu_halt_o,
    output reg           irq_block_o,
    output reg           rww_blocked_o,
    // Flash array side
    output reg           flash_start_o,
    output reg           flash_erase_o,
    output reg  [AW-1:0] flash_addr_o,
    input  wire          flash_done_i,
    // AXI4-Lite slave
    input  wire [7:0]    s_axi_awaddr,
    input  wire          s_axi_awvalid,
    output reg           s_axi_awready,
    input  wire [31:0]   s_axi_wdata,
    input  wire [3:0]    s_axi_wstrb,
    input  wire          s_axi_wvalid,
    output reg           s_axi_wready,
    output reg  [1:0]    s_axi_bresp,
    output reg           s_axi_bvalid,
    input  wire          s_axi_bready,
    input  wire [7:0]    s_axi_araddr,
    input  wire          s_axi_arvalid,
    output reg           s_axi_arready,
    output reg  [31:0]   s_axi_rdata,
    output reg  [1:0]    s_axi_rresp,
    output reg           s_axi_rvalid,
    input  wire          s_axi_rready
);

    // ------------------------------------------------------------------
    // States
    // ------------------------------------------------------------------
    localparam [1:0] ST_IDLE = 2'd0;
    localparam [1:0] ST_RWW  = 2'd1;
    localparam [1:0] ST_NO_READ_WHILE_WRITE_REGION = 2'd2;

    reg [1:0]    state_q;
    reg [1:0]    fuse_m_q;
    reg [1:0]    fuse_q;
    reg [3:0]    lock_q;
    reg          busy_q;
    reg          aw_have_q;
    reg          w_have_q;
    reg [7:0]    aw_addr_q;
    reg [31:0]   w_data_q;
    reg [3:0]    w_strb_q;

    // ------------------------------------------------------------------
    // Region decode
    // ------------------------------------------------------------------
    // Clamping keeps the boot part inside the fixed no-read-while-write
    // region even for a size setting larger than that region.
    function [AW-1:0] boot_start;
        input [1:0] sz;
        reg   [AW-1:0] s;
        begin
            s = {AW{1'b0}};
            case (sz)
                2'd0:    s = {AW{1'b0}} - BOOT_SZ0[AW-1:0];
                2'd1:    s = {AW{1'b0}} - BOOT_SZ1[AW-1:0];
                2'd2:    s = {AW{1'b0}} - BOOT_SZ2[AW-1:0];
                default: s = {AW{1'b0}} - BOOT_SZ3[AW-1:0];
            endcase
            if (s < NO_READ_WHILE_WRITE_REGION_START[AW-1:0])
                s = NO_READ_WHILE_WRITE_REGION_START[AW-1:0];
            boot_start = s;
        end
    endfunction

    wire [AW-1:0] boot_base  = boot_start(fuse_q);
    wire          pc_boot    = (cpu_pc_i >= boot_base);
    wire          spm_boot   = (spm_addr_i >= boot_base);
    wire          lpm_boot   = (lpm_addr_i >= boot_base);
    wire          spm_no_read_while_write_region   = (spm_addr_i >= NO_READ_WHILE_WRITE_REGION_START[AW-1:0]);

    // All four lock fields gate loads and stores: the LO fields stores, the HI fields loads.
    wire app_st_blk  = ~lock_q[`FSP_LOCK_APP_LO];
    wire app_ld_blk  = ~lock_q[`FSP_LOCK_APP_HI];
    wire boot_st_blk = ~lock_q[`FSP_LOCK_BOOT_LO];
    wire boot_ld_blk = ~lock_q[`FSP_LOCK_BOOT_HI];

    wire spm_prog  = (spm_kind_i == `FSP_OP_ERASE) | (spm_kind_i == `FSP_OP_WRITE);
    wire spm_lock  = (spm_kind_i == `FSP_OP_LOCK);
    wire tgt_block = spm_boot ? boot_st_blk : app_st_blk;
    wire spm_go    = spm_req_i & pc_boot & (state_q == ST_IDLE)
                   & spm_prog & ~tgt_block;
    wire spm_lk    = spm_req_i & pc_boot & (state_q == ST_IDLE) & spm_lock;
    wire lpm_blk   = (pc_boot & ~lpm_boot & app_ld_blk)
                   | (~pc_boot & lpm_boot & boot_ld_blk);

    // ------------------------------------------------------------------
    // AXI write decode
    // ------------------------------------------------------------------
    wire aw_take  = s_axi_awvalid & s_axi_awready;
    wire w_take   = s_axi_wvalid & s_axi_wready;
    wire aw_now   = aw_have_q | aw_take;
    wire w_now    = w_have_q | w_take;
    wire [7:0]  wa = aw_have_q ? aw_addr_q : s_axi_awaddr;
    wire [31:0] wd = w_have_q ? w_data_q : s_axi_wdata;
    wire [3:0]  ws = w_have_q ? w_strb_q : s_axi_wstrb;
    wire wr_fire  = aw_now & w_now & ~s_axi_bvalid;
    wire wr_map   = (wa == `FSP_OFS_CTRL) | (wa == `FSP_OFS_LOCK)
                  | (wa == `FSP_OFS_CONF);
    wire sw_clr   = wr_fire & (wa == `FSP_OFS_CTRL) & ws[0] & wd[`FSP_CTRL_CLR];
    wire sw_lock  = wr_fire & (wa == `FSP_OFS_LOCK) & ws[0];

    // ------------------------------------------------------------------
    // Fuse synchroniser
    // ------------------------------------------------------------------
    always @(posedge mclk_i)
    begin
        if (srst_i)
        begin
            fuse_m_q <= 2'h0;
            fuse_q   <= 2'h0;
        end
        else if (ce_i)
        begin
            fuse_m_q <= boot_size_fuses_i;
            fuse_q   <= fuse_m_q;
        end
    end

    // ------------------------------------------------------------------
    // Lock fields
    // ------------------------------------------------------------------
    // Writes can only move bits from 1 to 0; chip erase or reset restores 1.
    always @(posedge mclk_i)
    begin
        if (srst_i)
            lock_q <= `FSP_LOCK_RST;
        else if (ce_i)
        begin
            if (chip_erase_i)
                lock_q <= `FSP_LOCK_RST;
            else
                lock_q <= lock_q
                        & (spm_lk ? spm_data_i : 4'hF)
                        & (ext_lock_we_i ? ext_lock_d_i : 4'hF)
                        & (sw_lock ? wd[3:0] : 4'hF);
        end
    end

    // ------------------------------------------------------------------
    // Programming sequencer
    // ------------------------------------------------------------------
    always @(posedge mclk_i)
    begin
        if (srst_i)
        begin
            state_q       <= ST_IDLE;
            busy_q        <= 1'b0;
            cpu_halt_o    <= 1'b0;
            flash_start_o <= 1'b0;
            flash_erase_o <= 1'b0;
            flash_addr_o  <= {AW{1'b0}};
            spm_deny_o    <= 1'b0;
        end
        else if (ce_i)
        begin
            flash_start_o <= spm_go;
            spm_deny_o    <= spm_req_i & ~spm_go & ~spm_lk;
            if (spm_go)
            begin
                flash_erase_o <= (spm_kind_i == `FSP_OP_ERASE);
                flash_addr_o  <= spm_addr_i;
            end
            // A new operation setting the flag wins over a clear.
            if (spm_go & ~spm_no_read_while_write_region)
                busy_q <= 1'b1;
            else if (sw_clr & (state_q == ST_IDLE))
                busy_q <= 1'b0;
            case (state_q)
                ST_IDLE:
                begin
                    if (spm_go & spm_no_read_while_write_region)
                    begin
                        state_q    <= ST_NO_READ_WHILE_WRITE_REGION;
                        cpu_halt_o <= 1'b1;
                    end
                    else if (spm_go)
                        state_q <= ST_RWW;
                end
                ST_RWW:
                begin
                    if (flash_done_i)
                        state_q <= ST_IDLE;
                end
                ST_NO_READ_WHILE_WRITE_REGION:
                begin
                    if (flash_done_i)
                    begin
                        state_q    <= ST_IDLE;
                        cpu_halt_o <= 1'b0;
                    end
                end
                default:
                begin
                    state_q    <= ST_IDLE;
                    cpu_halt_o <= 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // CPU answers
    // ------------------------------------------------------------------
    always @(posedge mclk_i)
    begin
        if (srst_i)
        begin
            lpm_ok_o      <= 1'b0;
            lpm_deny_o    <= 1'b0;
            irq_block_o   <= 1'b0;
            rww_blocked_o <= 1'b0;
        end
        else if (ce_i)
        begin
            lpm_ok_o      <= lpm_req_i & ~lpm_blk;
            lpm_deny_o    <= lpm_req_i & lpm_blk;
            irq_block_o   <= (ivec_boot_i & ~pc_boot & app_ld_blk)
                           | (~ivec_boot_i & pc_boot & boot_ld_blk);
            rww_blocked_o <= busy_q;
        end
    end

    // ------------------------------------------------------------------
    // AXI write channel
    // ------------------------------------------------------------------
    always @(posedge mclk_i)
    begin
        if (srst_i)
        begin
            aw_have_q     <= 1'b0;
            w_have_q      <= 1'b0;
            aw_addr_q     <= 8'h00;
            w_data_q      <= 32'h0000_0000;
            w_strb_q      <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `FSP_RESP_OKAY;
        end
        else if (ce_i)
        begin
            if (aw_take)
                aw_addr_q <= s_axi_awaddr;
            if (w_take)
            begin
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (wr_fire)
            begin
                aw_have_q    <= 1'b0;
                w_have_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_map ? `FSP_RESP_OKAY : `FSP_RESP_SLVERR;
            end
            else
            begin
                aw_have_q <= aw_now;
                w_have_q  <= w_now;
                if (s_axi_bvalid & s_axi_bready)
                    s_axi_bvalid <= 1'b0;
            end
            s_axi_awready <= ~aw_now & ~wr_fire & ~s_axi_awready;
            s_axi_wready  <= ~w_now & ~wr_fire & ~s_axi_wready;
        end
    end

    // ------------------------------------------------------------------
    // AXI read channel
    // ------------------------------------------------------------------
    always @(posedge mclk_i)
    begin
        if (srst_i)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `FSP_RESP_OKAY;
        end
        else if (ce_i)
        begin
            s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
            if (s_axi_arvalid & s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= `FSP_RESP_OKAY;
                s_axi_rdata  <= 32'h0000_0000;
                case (s_axi_araddr)
                    `FSP_OFS_CTRL:
                    begin
                        s_axi_rdata[`FSP_CTRL_BUSY] <= busy_q;
                        s_axi_rdata[`FSP_CTRL_HALT] <= cpu_halt_o;
                    end
                    `FSP_OFS_LOCK:
                        s_axi_rdata[3:0] <= lock_q;
                    `FSP_OFS_CONF:
                    begin
                        s_axi_rdata[`FSP_CONF_FUSE_LSB+1:`FSP_CONF_FUSE_LSB] <= fuse_q;
                        s_axi_rdata[`FSP_CONF_BOOT_LSB+AW-1:`FSP_CONF_BOOT_LSB]
                            <= boot_base;
                    end
                    default:
                        s_axi_rresp <= `FSP_RESP_SLVERR;
                endcase
            end
            else if (s_axi_rvalid & s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

endmodule // fsp_top

// [bench/fsp_flash_model.sv]
// Flash array stand-in: answers each start with a one-cycle done pulse.
// Assumes the block's clock and reset; slow_i stretches each operation.
`timescale 1ns/100ps

module fsp_flash_model (
    // Clock and reset
    input  wire mclk_i,
    input  wire srst_i,
    // Block side
    input  wire flash_start_i,
    input  wire slow_i,
    output reg  flash_done_o
);
    reg [5:0] cnt_q;

    // A slow operation keeps the busy region closed long enough to poll it.
    always @(posedge mclk_i)
    begin
        if (srst_i)
        begin
            cnt_q        <= 6'h00;
            flash_done_o <= 1'b0;
        end
        else
        begin
            flash_done_o <= (cnt_q == 6'h01);
            if (flash_start_i)
                cnt_q <= slow_i ? 6'h1E : 6'h01;
            else if (cnt_q != 6'h00)
                cnt_q <= cnt_q - 6'h01;
        end
    end
endmodule // fsp_flash_model

// [bench/fsp_top_properties.sv]
// Checker of protection and handshake properties at the block's ports.
// Assumes it is bound into fsp_top and shares its one clock and reset.
`timescale 1ns/100ps

module fsp_props #(
    parameter AW         = 13,
    parameter NO_READ_WHILE_WRITE_REGION_START = 13'h1C00
) (
    // Clock, reset, enable
    input wire          mclk_i,
    input wire          srst_i,
    input wire          ce_i,
    // CPU side
    input wire [AW-1:0] cpu_pc_i,
    input wire          spm_req_i,
    input wire          lpm_req_i,
    input wire [AW-1:0] lpm_addr_i,
    input wire          lpm_ok_o,
    input wire          lpm_deny_o,
    input wire          spm_deny_o,
    input wire          cpu_halt_o,
    input wire          rww_blocked_o,
    // Flash side
    input wire          flash_start_o,
    input wire [AW-1:0] flash_addr_o,
    input wire          flash_done_i,
    // Bus answers
    input wire          s_axi_bvalid,
    input wire          s_axi_bready,
    input wire          s_axi_rvalid,
    input wire          s_axi_rready
);
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (srst_i);

    // The boot part never starts below the fixed region limit, so this is application code.
    a_app_store_void: assert property (spm_req_i && ce_i && cpu_pc_i < NO_READ_WHILE_WRITE_REGION_START
        |=> spm_deny_o && !flash_start_o) else $error("store from application acted");
    a_no_read_while_write_region_halts: assert property (flash_start_o && flash_addr_o >= NO_READ_WHILE_WRITE_REGION_START
        |-> cpu_halt_o) else $error("no halt for fixed region store");
    a_halt_holds: assert property (cpu_halt_o && !flash_done_i
        |=> cpu_halt_o) else $error("halt dropped early");
    a_halt_release: assert property (cpu_halt_o && flash_done_i && ce_i
        |=> !cpu_halt_o) else $error("halt not released");
    a_rww_runs: assert property (flash_start_o && flash_addr_o < NO_READ_WHILE_WRITE_REGION_START
        |-> !cpu_halt_o ##1 rww_blocked_o) else $error("busy region handling wrong");
    a_busy_cause: assert property ($rose(rww_blocked_o)
        |-> $past(flash_start_o)) else $error("busy without start");
    a_load_answer: assert property (lpm_req_i && ce_i
        |=> lpm_ok_o != lpm_deny_o) else $error("load answer malformed");
    a_app_load_free: assert property (lpm_req_i && ce_i && cpu_pc_i < NO_READ_WHILE_WRITE_REGION_START
        && lpm_addr_i < NO_READ_WHILE_WRITE_REGION_START |=> lpm_ok_o) else $error("application load denied");
    a_bvalid_stands: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid) else $error("write answer withdrawn");
    a_rvalid_stands: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid) else $error("read answer withdrawn");

    c_halt: cover property (flash_start_o && cpu_halt_o);
    c_busy: cover property ($rose(rww_blocked_o));
    c_deny: cover property (lpm_deny_o);
endmodule // fsp_props

bind fsp_top fsp_props #(.AW(AW), .NO_READ_WHILE_WRITE_REGION_START(NO_READ_WHILE_WRITE_REGION_START)) u_props (
    .mclk_i, .srst_i, .ce_i, .cpu_pc_i, .spm_req_i, .lpm_req_i, .lpm_addr_i,
    .lpm_ok_o, .lpm_deny_o, .spm_deny_o, .cpu_halt_o, .rww_blocked_o,
    .flash_start_o, .flash_addr_o, .flash_done_i, .s_axi_bvalid, .s_axi_bready,
    .s_axi_rvalid, .s_axi_rready
);

// [bench/test_fsp_top.sv]
// Self-checking bench for fsp_top: lock tables, store gating, halts, bus.
// Assumes fsp_flash_model as the flash array and fsp_props bound in.
`timescale 1ns/100ps
`include "fsp_defines.vh"

module test_fsp_top;
    typedef struct packed {
        logic [3:0]  lk;
        logic [12:0] pc, la;
        logic        ld;
        logic [12:0] sa;
        logic        ss;
    } fsp_row_t;

    logic        mclk_i = 1'b0, srst_i = 1'b1, ce_i = 1'b1, slow = 1'b0;
    logic        chip_erase_i = 1'b0, ext_lock_we_i = 1'b0, ivec_boot_i = 1'b0;
    logic        spm_req_i = 1'b0, lpm_req_i = 1'b0, s_axi_awvalid = 1'b0;
    logic        s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic        s_axi_rready = 1'b0;
    logic [1:0]  boot_size_fuses_i = 2'h2, spm_kind_i = 2'h0, r;
    logic [3:0]  ext_lock_d_i = 4'hF, spm_data_i = 4'hF, s_axi_wstrb = 4'hF;
    logic [12:0] cpu_pc_i = 13'h0000, spm_addr_i = 13'h0000, lpm_addr_i = 13'h0000;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0000_0000, d;
    wire         lpm_ok_o, lpm_deny_o, spm_deny_o, cpu_halt_o, irq_block_o;
    wire         rww_blocked_o, flash_start_o, flash_erase_o, flash_done_i;
    wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [12:0]  flash_addr_o;
    wire [1:0]   s_axi_bresp, s_axi_rresp;
    wire [31:0]  s_axi_rdata;
    int          fail_count = 0, checked = 0;

    // Boot part starts at 0x1E00 with size fuses at 2; 0x1C00 up is the fixed region.
    fsp_row_t rows [10] = '{
        '{4'hF, 13'h1F00, 13'h0100, 1'b0, 13'h0100, 1'b1},
        '{4'hD, 13'h1F00, 13'h0100, 1'b1, 13'h0100, 1'b1},
        '{4'hC, 13'h1F00, 13'h0100, 1'b1, 13'h0100, 1'b0},
        '{4'hE, 13'h1F00, 13'h0100, 1'b0, 13'h0100, 1'b0},
        '{4'h7, 13'h0100, 13'h1F00, 1'b1, 13'h0200, 1'b0},
        '{4'h3, 13'h0100, 13'h1F00, 1'b1, 13'h1F00, 1'b0},
        '{4'hB, 13'h1F00, 13'h1F80, 1'b0, 13'h1F80, 1'b0},
        '{4'hF, 13'h1F00, 13'h1F80, 1'b0, 13'h1F80, 1'b1},
        '{4'h7, 13'h1F00, 13'h1F80, 1'b0, 13'h1D00, 1'b1},
        '{4'h0, 13'h0100, 13'h0200, 1'b0, 13'h0100, 1'b0}};

    fsp_top dut (
        .mclk_i, .srst_i, .ce_i, .boot_size_fuses_i, .chip_erase_i, .ext_lock_we_i,
        .ext_lock_d_i, .cpu_pc_i, .ivec_boot_i, .spm_req_i, .spm_kind_i, .spm_addr_i,
        .spm_data_i, .lpm_req_i, .lpm_addr_i, .lpm_ok_o, .lpm_deny_o, .spm_deny_o,
        .cpu_halt_o, .irq_block_o, .rww_blocked_o, .flash_start_o, .flash_erase_o,
        .flash_addr_o, .flash_done_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    fsp_flash_model u_flash (.mclk_i, .srst_i, .flash_start_i(flash_start_o),
        .slow_i(slow), .flash_done_o(flash_done_i));

    initial forever #10 mclk_i = ~mclk_i;

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic stop_test;
        $display("Comparisons %0d, mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tmo;
        fail_count++;
        $display("[FAIL] %0t wait ran out", $time);
        stop_test;
    endtask
    // Every task starts and ends just after a rising edge.
    task automatic axw(input logic [7:0] a, input logic [31:0] v);
        int n;
        @(posedge mclk_i);
        s_axi_awaddr <= a; s_axi_wdata <= v; s_axi_bready <= 1'b1;
        s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1;
        for (n = 0; n < 40; n++)
        begin
            @(posedge mclk_i);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        if (n == 40) tmo;
    endtask
    task automatic axr(input logic [7:0] a);
        int n;
        @(posedge mclk_i);
        s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
        for (n = 0; n < 40; n++)
        begin
            @(posedge mclk_i);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        d = s_axi_rdata; r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        if (n == 40) tmo;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        axr(a); chk(d, e); chk(r, `FSP_RESP_OKAY);
    endtask
    task automatic relock(input logic [3:0] lk);
        chip_erase_i <= 1'b1; @(posedge mclk_i); chip_erase_i <= 1'b0;
        axw(`FSP_OFS_LOCK, {28'h000_0000, lk});
    endtask
    task automatic issue(input logic [1:0] k, input logic [12:0] a);
        spm_kind_i <= k; spm_addr_i <= a; spm_req_i <= 1'b1;
        @(posedge mclk_i); spm_req_i <= 1'b0; @(posedge mclk_i);
    endtask
    task automatic st(input logic [1:0] k, input logic [12:0] a, input logic e);
        int n;
        issue(k, a); chk(flash_start_o, e); chk(spm_deny_o, !e);
        if (e)
        begin
            chk(cpu_halt_o, a >= 13'h1C00); chk(flash_erase_o, k == 2'h0); chk(flash_addr_o, a);
            for (n = 0; n < 100 && !flash_done_i; n++) @(posedge mclk_i);
            if (n == 100) tmo;
            @(posedge mclk_i); chk(cpu_halt_o, 1'b0);
        end
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial
    begin
        repeat (12) @(posedge mclk_i);
        srst_i <= 1'b0;
        repeat (3) @(posedge mclk_i);
        chk({cpu_halt_o, rww_blocked_o, flash_start_o}, 3'h0);
        rdchk(`FSP_OFS_LOCK, 32'h0000_000F);
        rdchk(`FSP_OFS_CONF, 32'h1E00_0002);
        foreach (rows[i])
        begin
            relock(rows[i].lk); rdchk(`FSP_OFS_LOCK, rows[i].lk);
            cpu_pc_i <= rows[i].pc; slow <= i[1]; lpm_addr_i <= rows[i].la; lpm_req_i <= 1'b1;
            @(posedge mclk_i); lpm_req_i <= 1'b0; @(posedge mclk_i);
            chk({lpm_deny_o, lpm_ok_o}, {rows[i].ld, !rows[i].ld});
            st({1'b0, i[0]}, rows[i].sa, rows[i].ss);
            rdchk(`FSP_OFS_CTRL, rows[i].ss && rows[i].sa < 13'h1C00);
            axw(`FSP_OFS_CTRL, 32'h0000_0002); rdchk(`FSP_OFS_CTRL, 32'h0000_0000);
        end
        // Locks only tighten from software or outside; only erase or reset loosens them.
        relock(4'hF); cpu_pc_i <= 13'h1F00; spm_data_i <= 4'h5;
        issue(2'h2, 13'h0000); chk({flash_start_o, spm_deny_o}, 2'h0);
        axw(`FSP_OFS_LOCK, 32'h0000_000F); rdchk(`FSP_OFS_LOCK, 32'h0000_0005);
        ext_lock_d_i <= 4'hE; ext_lock_we_i <= 1'b1; @(posedge mclk_i); ext_lock_we_i <= 1'b0;
        rdchk(`FSP_OFS_LOCK, 32'h0000_0004);
        relock(4'hF); rdchk(`FSP_OFS_LOCK, 32'h0000_000F);
        st(2'h3, 13'h0100, 1'b0);
        relock(4'hD); ivec_boot_i <= 1'b1; cpu_pc_i <= 13'h0100;
        repeat (3) @(posedge mclk_i); chk(irq_block_o, 1'b1);
        cpu_pc_i <= 13'h1F00; repeat (3) @(posedge mclk_i); chk(irq_block_o, 1'b0);
        relock(4'h7); ivec_boot_i <= 1'b0;
        repeat (3) @(posedge mclk_i); chk(irq_block_o, 1'b1);
        axw(8'h0C, 32'h0000_0001); chk(r, `FSP_RESP_SLVERR);
        axr(8'h0C); chk(r, `FSP_RESP_SLVERR);
        stop_test;
    end
endmodule // test_fsp_top
